// >>> src/cec_ctrl.v
// config nvm controller: registers, table walk, store and restore engine
// Summary of operation
// - table of descriptors gives start address and byte count per segment
// - table opcodes: register update is executed, end-of-data stops the walk
// - reset table covers all registers, then an update command and end-of-data
// - busy bit 0 reads 1 while a transfer runs, else 0; read-only
// - with pin select set, busy also drives the status pin
// - error bit 0 set when restored data fails the check; read-only
// - load pin low and soft reload bit: reset, restore, bit self-clears
// - write enable resets to 0 and must be 1 before any nvm write
// - store bit starts buffer-to-nvm copy, cleared when copy finishes
// - update command copies buffer to active on next serial clock rise
`timescale 1ns/100ps
`default_nettype none
`include "cec_regs.vh"
module cec_ctrl #(
  parameter NVM_AW = 10
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire sclk_rise_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [11:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire nvm_load_n_i,
  output reg nvm_req_o,
  output reg nvm_we_o,
  output reg [NVM_AW-1:0] nvm_addr_o,
  output reg [7:0] nvm_wdata_o,
  input wire [7:0] nvm_rdata_i,
  input wire nvm_ack_i,
  output reg [11:0] buf_addr_o,
  output reg buf_we_o,
  output reg [7:0] buf_wdata_o,
  input wire [7:0] buf_rdata_i,
  output reg io_update_o,
  output reg soft_rst_o,
  output reg status_pin_o
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_OP = 8'h02;
  localparam [7:0] S_AHI = 8'h04;
  localparam [7:0] S_ALO = 8'h08;
  localparam [7:0] S_XFER = 8'h10;
  localparam [7:0] S_WAIT = 8'h20;
  localparam [7:0] S_NEXT = 8'h40;
  localparam [7:0] S_SUM = 8'h80;

  reg [7:0] state_r;
  reg busy_r;
  reg err_r;
  reg wen_r;
  reg soft_r;
  reg store_r;
  reg pinsel_r;
  reg upd_pend_r;
  reg dir_store_r;
  reg sum_wait_r;
  reg [4:0] ptr_r;
  reg [6:0] cnt_r;
  wire [7:0] tab_byte;
  wire [7:0] sum;
  wire tab_hit;
  wire tab_wr;
  wire [11:0] tab_off;
  reg sum_clr;
  reg sum_add;
  reg [7:0] sum_din;

  // table window decode; the offset only means something on a hit
  assign tab_off = reg_addr_i - `CEC_TAB_BASE;
  assign tab_hit = reg_addr_i >= `CEC_TAB_BASE &&
                   reg_addr_i <= `CEC_TAB_LAST;
  // table edits during a walk are dropped to keep the walk consistent
  assign tab_wr = reg_wr_i && tab_hit && !busy_r;

  cec_seg_table #(
    .N(`CEC_TAB_N)
  ) u_tab (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .wr_i(tab_wr),
    .waddr_i(tab_off[4:0]),
    .wdata_i(reg_wdata_i),
    .raddr_i(busy_r ? ptr_r : tab_off[4:0]),
    .rdata_o(tab_byte)
  );

  cec_sum u_sum (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_i(sum_clr),
    .add_i(sum_add),
    .din_i(sum_din),
    .sum_o(sum)
  );

  // checksum feed: stored bytes come from the bank, restored ones from nvm
  always @* begin
    sum_clr = state_r == S_IDLE;
    sum_add = state_r == S_WAIT && nvm_ack_i;
    sum_din = dir_store_r ? nvm_wdata_o : nvm_rdata_i;
  end

  // registered read port, data valid the cycle after reg_rd_i
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (tab_hit) begin
        reg_rdata_o <= tab_byte;
      end else if (reg_addr_i == `CEC_BUSY_ADDR) begin
        reg_rdata_o <= {7'h00, busy_r};
      end else if (reg_addr_i == `CEC_ERR_ADDR) begin
        reg_rdata_o <= {7'h00, err_r};
      end else if (reg_addr_i == `CEC_CTL_ADDR) begin
        reg_rdata_o <= {6'h00, soft_r, wen_r};
      end else if (reg_addr_i == `CEC_STORE_ADDR) begin
        reg_rdata_o <= {7'h00, store_r};
      end else begin
        reg_rdata_o <= 8'h00; // other registers live in the bank
      end
    end
  end

  // control bits; self-clearing bits drop when their walk ends
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wen_r <= 1'b0;
      soft_r <= 1'b0;
      store_r <= 1'b0;
      pinsel_r <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `CEC_PINSEL_ADDR) begin
        pinsel_r <= reg_wdata_i[`CEC_PINSEL_BIT];
      end
      if (reg_wr_i && reg_addr_i == `CEC_CTL_ADDR) begin
        wen_r <= reg_wdata_i[`CEC_WEN_BIT];
      end
      // soft reload only honoured with the load pin low
      if (reg_wr_i && reg_addr_i == `CEC_CTL_ADDR &&
          reg_wdata_i[`CEC_SOFT_BIT] && !nvm_load_n_i) begin
        soft_r <= 1'b1;
      end else if (state_r == S_SUM && sum_wait_r && nvm_ack_i &&
                   !dir_store_r) begin
        soft_r <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `CEC_STORE_ADDR &&
          reg_wdata_i[`CEC_STORE_BIT]) begin
        store_r <= 1'b1;
      end else if (store_r && !wen_r && !busy_r) begin
        store_r <= 1'b0; // protected: dropped, nvm untouched
      end else if (state_r == S_SUM && sum_wait_r && nvm_ack_i &&
                   dir_store_r) begin
        store_r <= 1'b0;
      end
    end
  end

  // update requests from host or table fire on the next serial clock rise
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upd_pend_r <= 1'b0;
      io_update_o <= 1'b0;
    end else begin
      io_update_o <= upd_pend_r && sclk_rise_i;
      if ((reg_wr_i && reg_addr_i == `CEC_UPD_ADDR &&
           reg_wdata_i[`CEC_UPD_BIT]) ||
          (state_r == S_OP && tab_byte[`CEC_OP_FLAG] &&
           tab_byte[6:0] == `CEC_OP_UPD)) begin
        upd_pend_r <= 1'b1; // new request wins over the clear
      end else if (sclk_rise_i) begin
        upd_pend_r <= 1'b0; // self-clearing
      end
    end
  end

  // busy on the status pin when selected
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_pin_o <= 1'b0;
    end else begin
      status_pin_o <= pinsel_r && busy_r;
    end
  end

  // table walk and byte mover
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      dir_store_r <= 1'b0;
      sum_wait_r <= 1'b0;
      ptr_r <= 5'h00;
      cnt_r <= 7'h00;
      nvm_req_o <= 1'b0;
      nvm_we_o <= 1'b0;
      nvm_addr_o <= {NVM_AW{1'b0}};
      nvm_wdata_o <= 8'h00;
      buf_addr_o <= 12'h000;
      buf_we_o <= 1'b0;
      buf_wdata_o <= 8'h00;
      soft_rst_o <= 1'b0;
    end else begin
      soft_rst_o <= 1'b0;
      buf_we_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          ptr_r <= 5'h00;
          nvm_addr_o <= {NVM_AW{1'b0}};
          // soft reload beats a pending store
          if (soft_r) begin
            soft_rst_o <= 1'b1;
            dir_store_r <= 1'b0;
            busy_r <= 1'b1;
            state_r <= S_OP;
          end else if (store_r && wen_r) begin
            dir_store_r <= 1'b1;
            busy_r <= 1'b1;
            state_r <= S_OP;
          end
        end
        S_OP: begin
          ptr_r <= ptr_r + 5'd1;
          if (tab_byte[`CEC_OP_FLAG]) begin
            // update opcode is latched by the update logic; any other ends
            if (tab_byte[6:0] != `CEC_OP_UPD) begin
              state_r <= S_SUM;
            end
          end else begin
            cnt_r <= tab_byte[6:0]; // count minus one
            state_r <= S_AHI;
          end
        end
        S_AHI: begin
          buf_addr_o[11:8] <= tab_byte[3:0];
          ptr_r <= ptr_r + 5'd1;
          state_r <= S_ALO;
        end
        S_ALO: begin
          buf_addr_o[7:0] <= tab_byte;
          ptr_r <= ptr_r + 5'd1;
          state_r <= S_XFER;
        end
        S_XFER: begin
          // bank data is combinational, so the address set in ALO is valid
          nvm_req_o <= 1'b1;
          nvm_we_o <= dir_store_r; // only set in a store walk, which starts only under write enable
          nvm_wdata_o <= buf_rdata_i;
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          // only a restore writes back; a stored byte leaves the bank alone
          if (nvm_ack_i) begin
            nvm_req_o <= 1'b0;
            nvm_we_o <= 1'b0;
            buf_we_o <= !dir_store_r;
            buf_wdata_o <= nvm_rdata_i;
            state_r <= S_NEXT;
          end
        end
        S_NEXT: begin
          // count holds bytes minus one, so zero means the segment is done
          buf_addr_o <= buf_addr_o + 12'd1;
          nvm_addr_o <= nvm_addr_o + {{(NVM_AW-1){1'b0}}, 1'b1};
          cnt_r <= cnt_r - 7'd1;
          state_r <= (cnt_r == 7'h00) ? S_OP : S_XFER;
        end
        S_SUM: begin
          // checksum byte follows the data in nvm
          if (!sum_wait_r) begin
            nvm_req_o <= 1'b1;
            nvm_we_o <= dir_store_r;
            nvm_wdata_o <= sum;
            sum_wait_r <= 1'b1;
          end else if (nvm_ack_i) begin
            nvm_req_o <= 1'b0;
            nvm_we_o <= 1'b0;
            sum_wait_r <= 1'b0;
            if (!dir_store_r) begin
              err_r <= nvm_rdata_i != sum;
            end
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
          busy_r <= 1'b0;
          nvm_req_o <= 1'b0;
          nvm_we_o <= 1'b0;
          sum_wait_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // cec_ctrl
`default_nettype wire

// >>> src/cec_regs.vh
// register map, field positions, defaults and opcodes of the config nvm controller
`ifndef CEC_REGS_VH
`define CEC_REGS_VH
`define CEC_AW 12
`define CEC_TAB_BASE 12'hA00
`define CEC_TAB_LAST 12'hA16
`define CEC_TAB_N 23
`define CEC_BUSY_ADDR 12'hB00
`define CEC_ERR_ADDR 12'hB01
`define CEC_CTL_ADDR 12'hB02
`define CEC_STORE_ADDR 12'hB03
`define CEC_UPD_ADDR 12'h232
`define CEC_PINSEL_ADDR 12'h01D
`define CEC_PINSEL_BIT 7
`define CEC_UPD_BIT 0
`define CEC_BUSY_BIT 0
`define CEC_ERR_BIT 0
`define CEC_WEN_BIT 0
`define CEC_SOFT_BIT 1
`define CEC_STORE_BIT 0
`define CEC_OP_FLAG 7
`define CEC_OP_END 7'h00
`define CEC_OP_UPD 7'h01
`define CEC_OP_END_BYTE 8'h80
`define CEC_OP_UPD_BYTE 8'h81
// default descriptors: {count-1, addr_hi, addr_lo} per segment
`define CEC_TAB_DEF {8'h03, 8'h00, 8'h00, 8'h4F, 8'h00, 8'h10, \
  8'h0D, 8'h00, 8'hF0, 8'h3F, 8'h01, 8'h40, 8'h01, 8'h01, 8'hE0, \
  8'h02, 8'h02, 8'h30, `CEC_OP_UPD_BYTE, `CEC_OP_END_BYTE, \
  `CEC_OP_END_BYTE, `CEC_OP_END_BYTE, `CEC_OP_END_BYTE}
`endif

// >>> src/cec_seg_table.v
// segment descriptor table storage with reset defaults
`timescale 1ns/100ps
`default_nettype none
`include "cec_regs.vh"
module cec_seg_table #(
  parameter N = `CEC_TAB_N
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire wr_i,
  input wire [4:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [4:0] raddr_i,
  output wire [7:0] rdata_o
);
  localparam [8*N-1:0] DEF = `CEC_TAB_DEF;
  wire [8*N-1:0] flat;
  genvar g;
  // one byte per entry; entry 0 sits in the top byte of the default
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ent
      reg [7:0] ent_r;
      always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ent_r <= DEF[8*(N-1-g) +: 8];
        end else if (wr_i && waddr_i == g) begin
          ent_r <= wdata_i;
        end
      end
      assign flat[8*g +: 8] = ent_r;
    end
  endgenerate
  // out-of-range index reads as end marker so a walk always stops
  assign rdata_o = (raddr_i < N) ? flat[8*raddr_i +: 8] : `CEC_OP_END_BYTE;
endmodule // cec_seg_table
`default_nettype wire

// >>> src/cec_sum.v
// running 8-bit checksum over transferred bytes
`timescale 1ns/100ps
`default_nettype none
module cec_sum (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire clr_i,
  input wire add_i,
  input wire [7:0] din_i,
  output reg [7:0] sum_o
);
  // clear wins: a walk never starts and adds in the same cycle
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sum_o <= 8'h00;
    end else if (clr_i) begin
      sum_o <= 8'h00;
    end else if (add_i) begin
      sum_o <= sum_o + din_i;
    end
  end
endmodule // cec_sum
`default_nettype wire

// >>> tb/cec_ctrl_checker.sv
// port-level assertions for the config nvm controller
`timescale 1ns/100ps
`default_nettype none
`include "cec_regs.vh"
module cec_ctrl_checker #(
  parameter NVM_AW = 10
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sclk_rise_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic nvm_load_n_i,
  input wire logic nvm_req_o,
  input wire logic nvm_we_o,
  input wire logic [NVM_AW-1:0] nvm_addr_o,
  input wire logic [7:0] nvm_wdata_o,
  input wire logic nvm_ack_i,
  input wire logic buf_we_o,
  input wire logic io_update_o,
  input wire logic soft_rst_o,
  input wire logic status_pin_o
);
  logic wen_r;
  logic psel_r;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // shadow of write enable and pin select, lenient on soft reload
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wen_r <= 1'b0;
      psel_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `CEC_CTL_ADDR) wen_r <= reg_wdata_i[0];
      if (reg_addr_i == `CEC_PINSEL_ADDR) psel_r <= reg_wdata_i[7];
    end
  end
  property p_hold;
    nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o)
      && $stable(nvm_we_o) && $stable(nvm_wdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("nvm request moved");
  property p_drop;
    nvm_req_o && nvm_ack_i |=> !nvm_req_o;
  endproperty
  a_drop: assert property (p_drop) else $error("nvm request held");
  property p_upd;
    io_update_o |-> $past(sclk_rise_i) && !$past(io_update_o);
  endproperty
  a_upd: assert property (p_upd) else $error("update off sclk");
  property p_wen;
    nvm_req_o && nvm_we_o |-> wen_r;
  endproperty
  a_wen: assert property (p_wen) else $error("write while locked");
  property p_pin;
    status_pin_o |-> $past(psel_r);
  endproperty
  a_pin: assert property (p_pin) else $error("pin without select");
  property p_soft;
    soft_rst_o |-> !$past(nvm_load_n_i);
  endproperty
  a_soft: assert property (p_soft) else $error("reload with pin high");
  property p_busy_ro;
    reg_rd_i && reg_addr_i == `CEC_BUSY_ADDR |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_busy_ro: assert property (p_busy_ro) else $error("busy byte");
  property p_err_ro;
    reg_rd_i && reg_addr_i == `CEC_ERR_ADDR |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("error byte");
  property p_bufwe;
    buf_we_o |-> $past(nvm_ack_i) && !$past(nvm_we_o);
  endproperty
  a_bufwe: assert property (p_bufwe) else $error("stray buffer write");
endmodule // cec_ctrl_checker
bind cec_ctrl cec_ctrl_checker #(.NVM_AW(NVM_AW)) cec_ctrl_checker_inst (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_rise_i(sclk_rise_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .nvm_load_n_i(nvm_load_n_i), .nvm_req_o(nvm_req_o), .nvm_we_o(nvm_we_o),
  .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o), .nvm_ack_i(nvm_ack_i),
  .buf_we_o(buf_we_o), .io_update_o(io_update_o), .soft_rst_o(soft_rst_o),
  .status_pin_o(status_pin_o));
`default_nettype wire

// >>> tb/cec_ctrl_tb_top.sv
// self-checking bench: defaults, store, restore, error and refusals
`timescale 1ns/100ps
`default_nettype none
`include "cec_regs.vh"
module cec_ctrl_tb_top;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, sclk_rise_i = 1'b0, slow = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, nvm_load_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000, base;
  logic [7:0] reg_wdata_i = 8'h00, got, sum;
  wire [7:0] reg_rdata_o, nvm_wdata_o, nvm_rdata_i, buf_wdata_o, buf_rdata_i;
  wire [9:0] nvm_addr_o;
  wire [11:0] buf_addr_o;
  wire nvm_req_o, nvm_we_o, nvm_ack_i, buf_we_o, io_update_o, soft_rst_o;
  wire status_pin_o;
  logic [7:0] bank [0:4095];
  int mismatches = 0, checks_done = 0, upd_n = 0, soft_n = 0, n, k;
  int upd0, soft0;
  logic pin_seen = 1'b0;
  localparam logic [183:0] TDEF = `CEC_TAB_DEF;
  always #10 ref_clk_i = ~ref_clk_i;
  // buffer bank answers at once, like the real register file
  assign buf_rdata_i = bank[buf_addr_o];
  always @(posedge ref_clk_i) begin
    if (buf_we_o === 1'b1) bank[buf_addr_o] <= buf_wdata_o;
    if (io_update_o === 1'b1) upd_n <= upd_n + 1;
    if (soft_rst_o === 1'b1) soft_n <= soft_n + 1;
    if (status_pin_o === 1'b1) pin_seen <= 1'b1;
    sclk_rise_i <= ($urandom % 4) == 0;
    slow <= $urandom % 2;
  end
  cec_ctrl #(.NVM_AW(10)) cec_ctrl_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .sclk_rise_i(sclk_rise_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .nvm_load_n_i(nvm_load_n_i),
    .nvm_req_o(nvm_req_o), .nvm_we_o(nvm_we_o), .nvm_addr_o(nvm_addr_o),
    .nvm_wdata_o(nvm_wdata_o), .nvm_rdata_i(nvm_rdata_i),
    .nvm_ack_i(nvm_ack_i), .buf_addr_o(buf_addr_o), .buf_we_o(buf_we_o),
    .buf_wdata_o(buf_wdata_o), .buf_rdata_i(buf_rdata_i),
    .io_update_o(io_update_o), .soft_rst_o(soft_rst_o),
    .status_pin_o(status_pin_o));
  cec_nvm_model cec_nvm_model_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .req_i(nvm_req_o), .we_i(nvm_we_o), .addr_i(nvm_addr_o),
    .wdata_i(nvm_wdata_o), .slow_i(slow), .ack_o(nvm_ack_i),
    .rdata_o(nvm_rdata_i));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 got = reg_rdata_o;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // poll busy under a bound; a hang ends the run
  task automatic wait_idle;
    for (k = 0; k < 500; k++) begin
      rd(`CEC_BUSY_ADDR);
      if (got[0] === 1'b0) break;
    end
    if (k == 500) begin
      mismatches++;
      $display("CHECK FAILED at %0t: busy timeout", $time);
      close_out;
    end
  endtask
  // a table update waits for a serial clock rise, so allow it bounded time
  task automatic wait_upd(input int u0);
    for (int j = 0; j < 64 && upd_n == u0; j++) @(posedge ref_clk_i);
    chk({7'h00, upd_n != u0}, 8'h01);
  endtask
  initial begin
    n = $urandom(44275);
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      rd(`CEC_TAB_BASE + 12'(i));
      chk(got, TDEF[(22 - i) * 8 +: 8]);
    end
    wr(`CEC_BUSY_ADDR, 8'hFF);
    rd(`CEC_BUSY_ADDR);
    chk(got, 8'h00);
    rd(`CEC_ERR_ADDR);
    chk(got, 8'h00);
    rd(`CEC_CTL_ADDR);
    chk(got, 8'h00);
    $display("test defaults done");
    // random one-segment table, then update and end opcodes
    n = 1 + $urandom % 4;
    base = 12'h100 + 12'($urandom % 64);
    wr(`CEC_TAB_BASE, 8'(n - 1));
    wr(`CEC_TAB_BASE + 12'h001, {4'h0, base[11:8]});
    wr(`CEC_TAB_BASE + 12'h002, base[7:0]);
    wr(`CEC_TAB_BASE + 12'h003, `CEC_OP_UPD_BYTE);
    wr(`CEC_TAB_BASE + 12'h004, `CEC_OP_END_BYTE);
    sum = 8'h00;
    for (int i = 0; i < n; i++) begin
      bank[base + 12'(i)] = 8'($urandom);
      sum = sum + bank[base + 12'(i)];
    end
    wr(`CEC_PINSEL_ADDR, 8'h80);
    wr(`CEC_STORE_ADDR, 8'h01);
    repeat (4) @(posedge ref_clk_i);
    rd(`CEC_STORE_ADDR);
    chk(got, 8'h00);
    chk(8'(cec_nvm_model_inst.wr_cnt), 8'h00);
    $display("test locked store done");
    wr(`CEC_CTL_ADDR, 8'h01);
    upd0 = upd_n;
    wr(`CEC_STORE_ADDR, 8'h01);
    rd(`CEC_BUSY_ADDR);
    chk(got, 8'h01);
    wr(`CEC_TAB_BASE + 12'h004, 8'h81);
    wait_idle;
    rd(`CEC_TAB_BASE + 12'h004);
    chk(got, `CEC_OP_END_BYTE);
    rd(`CEC_STORE_ADDR);
    chk(got, 8'h00);
    for (int i = 0; i < n; i++)
      chk(cec_nvm_model_inst.mem[i], bank[base + 12'(i)]);
    chk(cec_nvm_model_inst.mem[n], sum);
    chk({7'h00, pin_seen}, 8'h01);
    chk({7'h00, status_pin_o}, 8'h00);
    wait_upd(upd0);
    $display("test store done");
    // wipe the segment and reload it from nvm
    for (int i = 0; i < n; i++) bank[base + 12'(i)] = ~bank[base + 12'(i)];
    upd0 = upd_n;
    wr(`CEC_CTL_ADDR, 8'h03);
    wait_idle;
    for (int i = 0; i < n; i++)
      chk(bank[base + 12'(i)], cec_nvm_model_inst.mem[i]);
    rd(`CEC_ERR_ADDR);
    chk(got, 8'h00);
    rd(`CEC_CTL_ADDR);
    chk({7'h00, got[1]}, 8'h00);
    chk(8'(soft_n), 8'h01);
    wait_upd(upd0);
    $display("test restore done");
    cec_nvm_model_inst.mem[0] = cec_nvm_model_inst.mem[0] ^ 8'h01;
    wr(`CEC_CTL_ADDR, 8'h02);
    wait_idle;
    rd(`CEC_ERR_ADDR);
    chk(got, 8'h01);
    @(posedge ref_clk_i);
    nvm_load_n_i <= 1'b1;
    soft0 = soft_n;
    wr(`CEC_CTL_ADDR, 8'h02);
    repeat (5) @(posedge ref_clk_i);
    chk(8'(soft_n - soft0), 8'h00);
    $display("test error and load pin done");
    close_out;
  end
endmodule // cec_ctrl_tb_top
`default_nettype wire

// >>> tb/cec_nvm_model.sv
// behavioural nonvolatile memory answering the controller's requests
`timescale 1ns/100ps
`default_nettype none
module cec_nvm_model (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:1023];
  int wait_n;
  int wr_cnt = 0;
  // ack after 2 to 7 extra cycles (0 to 5 for the first request after reset); data toggles when not valid
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      wait_n <= 0;
      rdata_o <= 8'h5A;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wait_n <= -2;
      rdata_o <= ~rdata_o;
    end else if (req_i && wait_n < (slow_i ? 5 : 0)) begin
      wait_n <= wait_n + 1;
      rdata_o <= ~rdata_o;
    end else if (req_i) begin
      ack_o <= 1'b1;
      wait_n <= 0;
      rdata_o <= mem[addr_i];
      if (we_i) begin
        mem[addr_i] <= wdata_i;
        wr_cnt <= wr_cnt + 1;
      end
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule // cec_nvm_model
`default_nettype wire
